// ===== bench/sfxip_ctrl_props.sv
// Purpose: concurrent checks on the xip mode control ports.
// Assumes: one clock domain, clk with reset rst_n.
// Notes:   a helper counter tracks cycles since reset release.
`timescale 1ns/1ps
// ------------------------------------------------------------
// checker
// ------------------------------------------------------------
module sfxip_ctrl_props #(
  parameter int PWRUP_CYCLES = 20
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // watched inputs
  input wire logic [2:0] nvcrXipField,
  input wire logic       welSet,
  input wire logic       engineBusy,
  // watched outputs
  input wire logic       xipActive_q,
  input wire logic       xipConfirmBit_q,
  input wire logic       powerUpBusy_q,
  input wire logic       cmdStrobe_q,
  input wire logic [7:0] cmdCode_q,
  input wire logic       cmdRejected_q,
  input wire logic       xipReadStrobe_q,
  input wire logic       writeEnableLatch_q,
  input wire logic       writeInProgress_q,
  input wire logic [1:0] lockBits_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int upCnt_q;
  // saturating count, so long runs never wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      upCnt_q <= 0;
    else if (upCnt_q < 100000)
      upCnt_q <= upCnt_q + 1;
  end
  sequence seqEnter;
    $rose(xipActive_q);
  endsequence
  sequence seqExit;
    $fell(xipActive_q);
  endsequence
  chk_boot_xip_field: assert property (upCnt_q == 1 |->
    xipActive_q == ($past(nvcrXipField) != 3'h7))
    else $error("boot xip state wrong");
  chk_boot_bits_clear: assert property (upCnt_q == 1 |->
    !writeEnableLatch_q && lockBits_q == 2'h0)
    else $error("status bits not clear at boot");
  chk_enter_confirm_zero: assert property (seqEnter |->
    !xipConfirmBit_q) else $error("xip entered with confirm 1");
  chk_exit_confirm_one: assert property (seqExit |->
    xipConfirmBit_q) else $error("xip left with confirm 0");
  chk_read_in_xip: assert property (xipReadStrobe_q |->
    xipActive_q && !xipConfirmBit_q) else $error("read outside xip");
  chk_reject_code: assert property (cmdStrobe_q |->
    cmdRejected_q == ($past(powerUpBusy_q) && !(cmdCode_q inside
    {8'h05, 8'h70}))) else $error("reject decision wrong");
  chk_reject_with_strobe: assert property (cmdRejected_q |->
    cmdStrobe_q) else $error("reject without strobe");
  chk_wel_blocked: assert property (powerUpBusy_q && welSet &&
    !writeEnableLatch_q |=> !writeEnableLatch_q)
    else $error("latch set in power-up");
  chk_busy_mirror: assert property ($past(rst_n) |->
    writeInProgress_q == $past(engineBusy)) else $error("busy mirror wrong");
  chk_powerup_span: assert property ((upCnt_q < PWRUP_CYCLES
    |-> powerUpBusy_q) and (upCnt_q >= PWRUP_CYCLES |->
    !powerUpBusy_q)) else $error("power-up window wrong");
endmodule // sfxip_ctrl_props

bind sfxip_ctrl sfxip_ctrl_props #(.PWRUP_CYCLES(PWRUP_CYCLES))
  sfxip_ctrl_props_i (.clk(clk), .rst_n(rst_n),
  .nvcrXipField(nvcrXipField), .welSet(welSet),
  .engineBusy(engineBusy), .xipActive_q(xipActive_q),
  .xipConfirmBit_q(xipConfirmBit_q), .powerUpBusy_q(powerUpBusy_q),
  .cmdStrobe_q(cmdStrobe_q), .cmdCode_q(cmdCode_q),
  .cmdRejected_q(cmdRejected_q), .xipReadStrobe_q(xipReadStrobe_q),
  .writeEnableLatch_q(writeEnableLatch_q),
  .writeInProgress_q(writeInProgress_q), .lockBits_q(lockBits_q));

// ===== bench/sfxip_host.sv
// Purpose: host controller model driving the serial link.
// Assumes: frames are queued with put, then sent with run.
// Notes:   clock stands still and lines flip between frames.
`timescale 1ns/1ps
// ------------------------------------------------------------
// host model
// ------------------------------------------------------------
module sfxip_host (
  // serial link toward the device
  output logic       serialClk,
  output logic       csN,
  output logic [3:0] io
);
  logic [3:0] nib [0:39];
  int         len;
  // idle link at time zero
  initial begin
    serialClk = 1'b0;
    csN = 1'b1;
    io = 4'h0;
    len = 0;
  end
  // queue w bits of v, lanes lines a clock, msb first on the highest used line (line0 for one lane)
  task automatic put(input logic [31:0] v, input int w, input int lanes);
    for (int i = w - lanes; i >= 0; i -= lanes) begin
      nib[len] = 4'(v >> i) & 4'((1 << lanes) - 1);
      len++;
    end
  endtask
  // one frame; the dummy nibble carries the confirm value
  task automatic run();
    #1 csN = 1'b0;
    for (int k = 0; k < len; k++) begin
      io = nib[k];
      #6 serialClk = 1'b1;
      #6 serialClk = 1'b0;
    end
    #3 csN = 1'b1; // rises before the next clock
    io = ~io;
    len = 0;
    #120; // deselect gap well over the minimum
  endtask
endmodule // sfxip_host

// ===== bench/tb_sfxip_ctrl.sv
// Purpose: self-checking bench for the xip mode control block.
// Assumes: power-up window shortened to 40 cycles.
// Notes:   a watcher latches one-cycle strobes between checks.
`timescale 1ns/1ps
// ------------------------------------------------------------
// testbench
// ------------------------------------------------------------
module tb_sfxip_ctrl;
  logic clk, rst_n, serialClk, csN, resetPinN, resetPinEnable;
  logic basicXip, vcrWrite, vcrXipData, protoWrite, welSet, welClear;
  logic engineBusy, lockWrite, xipActive_q, xipConfirmBit_q;
  logic vcrXipBit_q, powerUpBusy_q, cmdStrobe_q, cmdRejected_q;
  logic xipReadStrobe_q, writeEnableLatch_q, writeInProgress_q;
  logic sawCmd, sawRej, sawRead;
  logic [1:0]  nvcrProtocol, protoData, lockData, protocol_q, lockBits_q;
  logic [2:0]  nvcrXipField;
  logic [3:0]  io;
  logic [7:0]  cmdCode_q;
  logic [23:0] readAddr_q;
  int n_errors, n_compared;

  sfxip_host sfxip_host_i (.serialClk(serialClk), .csN(csN), .io(io));
  sfxip_ctrl #(.PWRUP_CYCLES(40)) sfxip_ctrl_i (.clk(clk),
    .rst_n(rst_n), .serialClk(serialClk), .csN(csN),
    .serialIoLine0(io[0]), .serialIoLine1(io[1]),
    .serialIoLine2(io[2]), .serialIoLine3(io[3]),
    .resetPinN(resetPinN), .resetPinEnable(resetPinEnable),
    .nvcrXipField(nvcrXipField), .nvcrProtocol(nvcrProtocol),
    .basicXip(basicXip), .vcrWrite(vcrWrite), .vcrXipData(vcrXipData),
    .protoWrite(protoWrite), .protoData(protoData), .welSet(welSet),
    .welClear(welClear), .engineBusy(engineBusy),
    .lockWrite(lockWrite), .lockData(lockData),
    .xipActive_q(xipActive_q), .protocol_q(protocol_q),
    .xipConfirmBit_q(xipConfirmBit_q), .vcrXipBit_q(vcrXipBit_q),
    .powerUpBusy_q(powerUpBusy_q), .cmdStrobe_q(cmdStrobe_q),
    .cmdCode_q(cmdCode_q), .cmdRejected_q(cmdRejected_q),
    .xipReadStrobe_q(xipReadStrobe_q), .readAddr_q(readAddr_q),
    .writeEnableLatch_q(writeEnableLatch_q),
    .writeInProgress_q(writeInProgress_q), .lockBits_q(lockBits_q));

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // strobes last one cycle, so latch them for later checks
  always @(posedge clk) begin
    if (cmdStrobe_q === 1'b1) begin
      sawCmd <= 1'b1;
      sawRej <= cmdRejected_q;
    end
    if (xipReadStrobe_q === 1'b1)
      sawRead <= 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic go();
    sawCmd = 1'b0;
    sawRej = 1'b0;
    sawRead = 1'b0;
    sfxip_host_i.run();
    repeat (2) @(negedge clk);
  endtask
  // pin reset into quad xip, select held high throughout
  task automatic reboot();
    nvcrXipField = 3'h0;
    nvcrProtocol = 2'h2;
    resetPinN = 1'b0;
    repeat (4) @(negedge clk);
    resetPinN = 1'b1;
    repeat (4) @(negedge clk);
    chk({xipActive_q, xipConfirmBit_q, protocol_q}, 4'ha);
  endtask
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end
  initial begin
    {rst_n, basicXip, vcrWrite, vcrXipData, protoWrite} = '0;
    {welSet, welClear, engineBusy, lockWrite, lockData} = '0;
    {nvcrProtocol, protoData, sawCmd, sawRej, sawRead} = '0;
    {resetPinN, resetPinEnable, nvcrXipField} = 5'h1f;
    repeat (3) @(negedge clk);
    chk({xipActive_q, powerUpBusy_q}, 2'h1);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({xipActive_q, writeEnableLatch_q, lockBits_q}, 0);
    lockData = 2'h3;
    pulse(lockWrite);
    pulse(welSet);
    sfxip_host_i.put(32'h9f, 8, 1);
    go();
    chk({sawCmd, sawRej}, 2'h3);
    sfxip_host_i.put(32'h05, 8, 1);
    go();
    chk({sawCmd, sawRej, writeEnableLatch_q, lockBits_q}, 5'h10);
    sfxip_host_i.put(32'h70, 8, 1);
    go();
    chk({sawCmd, sawRej, cmdCode_q}, 10'h270);
    for (int i = 0; i < 60 && powerUpBusy_q !== 1'b0; i++)
      @(negedge clk);
    sfxip_host_i.put(32'h9f, 8, 1);
    go();
    chk({sawCmd, sawRej, powerUpBusy_q}, 3'h4);
    $display("test power-up done");
    pulse(vcrWrite);
    sfxip_host_i.put(32'h0b00_0100, 32, 1);
    sfxip_host_i.put(32'h0, 1, 1);
    go();
    chk({xipActive_q, xipConfirmBit_q, cmdCode_q}, 10'h20b);
    sfxip_host_i.put(32'habcdef, 24, 1);
    sfxip_host_i.put(32'h0, 1, 1);
    go();
    chk({sawRead, readAddr_q}, 25'h1abcdef);
    sfxip_host_i.put(32'h0, 24, 1);
    sfxip_host_i.put(32'h1, 1, 1);
    go();
    chk({xipActive_q, vcrXipBit_q, sawRead}, 3'h2);
    sfxip_host_i.put(32'h05, 8, 1);
    go();
    chk({sawCmd, cmdCode_q}, 9'h105);
    basicXip = 1'b1;
    sfxip_host_i.put(32'h0b00_0200, 32, 1);
    sfxip_host_i.put(32'h0, 1, 1);
    go();
    chk({xipActive_q, vcrXipBit_q}, 2'h3);
    basicXip = 1'b0;
    $display("test volatile entry done");
    reboot();
    sfxip_host_i.put(32'h123456e, 28, 4);
    go();
    chk({sawRead, xipActive_q, readAddr_q}, 26'h3123456);
    protoData = 2'h1;
    pulse(protoWrite);
    sfxip_host_i.put(32'h654321, 24, 2);
    sfxip_host_i.put(32'h2, 2, 2);
    go();
    chk({sawRead, xipActive_q, readAddr_q}, 26'h3654321);
    engineBusy = 1'b1;
    pulse(welSet);
    repeat (13) sfxip_host_i.put(32'h1, 4, 4);
    go();
    chk({xipActive_q, xipConfirmBit_q}, 2'h1);
    chk({writeInProgress_q, writeEnableLatch_q}, 2'h3);
    engineBusy = 1'b0;
    $display("test xip exit done");
    reboot();
    repeat (7) sfxip_host_i.put(32'h9, 4, 4);
    go();
    repeat (13) sfxip_host_i.put(32'h9, 4, 4);
    go();
    repeat (25) sfxip_host_i.put(32'h9, 4, 4);
    go();
    repeat (8) sfxip_host_i.put(32'h9, 4, 4);
    go();
    chk({xipActive_q, protocol_q}, 3'h0);
    nvcrXipField = 3'h7;
    $display("test rescue done");
    stop_test();
  end
endmodule // tb_sfxip_ctrl

// ===== logic/sfxip_ctrl.sv
// Purpose: execute-in-place mode control of a multi-line serial flash.
// Assumes: host drives serialClk and csN; link flops use serialClk.
// Notes:   frame contents cross to clk only while csN is high.

`timescale 1ns/1ps

module sfxip_ctrl #(
  parameter int PWRUP_CYCLES = sfxip_pkg::PWRUP_CYCLES
) (
  // system clock and power-on reset indication
  input  wire logic        clk,
  input  wire logic        rst_n,
  // serial link from the host
  input  wire logic        serialClk,
  input  wire logic        csN,
  input  wire logic        serialIoLine0,
  input  wire logic        serialIoLine1,
  input  wire logic        serialIoLine2,
  input  wire logic        serialIoLine3,
  // hardware reset pin and its enable
  input  wire logic        resetPinN,
  input  wire logic        resetPinEnable,
  // nonvolatile configuration seen at boot
  input  wire logic [2:0]  nvcrXipField,
  input  wire logic [1:0]  nvcrProtocol,
  input  wire logic        basicXip,
  // volatile configuration writes
  input  wire logic        vcrWrite,
  input  wire logic        vcrXipData,
  input  wire logic        protoWrite,
  input  wire logic [1:0]  protoData,
  // write latch and lock updates from the command engines
  input  wire logic        welSet,
  input  wire logic        welClear,
  input  wire logic        engineBusy,
  input  wire logic        lockWrite,
  input  wire logic [1:0]  lockData,
  // mode state
  output logic             xipActive_q,
  output logic [1:0]       protocol_q,
  output logic             xipConfirmBit_q,
  output logic             vcrXipBit_q,
  output logic             powerUpBusy_q,
  // decoded frames
  output logic             cmdStrobe_q,
  output logic [7:0]       cmdCode_q,
  output logic             cmdRejected_q,
  output logic             xipReadStrobe_q,
  output logic [23:0]      readAddr_q,
  // status bits
  output logic             writeEnableLatch_q,
  output logic             writeInProgress_q,
  output logic [1:0]       lockBits_q
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  localparam int PCNT_W = $clog2(PWRUP_CYCLES + 1);

  logic [sfxip_pkg::IO_W-1:0]       ioMem_q [sfxip_pkg::EDGE_DEPTH];
  logic [sfxip_pkg::EDGE_CNT_W-1:0] edgeCnt_q;
  logic                             frameStart_q;
  logic                             frameTog_q;
  logic                             allOnes_q;
  logic [sfxip_pkg::EDGE_CNT_W-1:0] edgeIdx;

  logic [2:0]        syncOut;
  logic              csSync;
  logic              rstPinSync;
  logic              togSync;
  logic              csPrev_q;
  logic              togSeen_q;
  logic              frameEnd;
  logic              bootPending_q;
  logic              viaVcr_q;
  logic [PCNT_W-1:0] pwrCnt_q;

  // decode results for the frame just closed
  int                decWidth;
  int                cmdClk;
  int                addrClk;
  int                confIdx;
  logic [7:0]        decCmd;
  logic [23:0]       decAddr;
  logic              decConfirm;
  logic              xipConfSeen;
  logic              cmdSeen;
  logic              enterXip;
  logic              exitXip;
  logic              rescueFf;
  logic              pinReset;
  logic              xipAllowed;

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // bits per clock (active lines) for the enabled protocol
  function automatic int protoWidth(input logic [1:0] p);
    int w;
    w = 1;
    unique case (p)
      sfxip_pkg::PROTO_DUAL: w = 2;
      sfxip_pkg::PROTO_QUAD: w = 4;
      default:               w = 1;
    endcase
    return w;
  endfunction

  // map a raw protocol code, the spare code falls back to extended
  function automatic logic [1:0] legalProto(input logic [1:0] p);
    logic [1:0] r;
    r = p;
    if (p == 2'h3) begin
      r = sfxip_pkg::PROTO_EXT;
    end
    return r;
  endfunction

  // assemble the first nClk captured groups msb first
  function automatic logic [23:0] gatherBits(input int nClk, input int w);
    logic [23:0] v;
    logic [3:0]  m;
    v = '0;
    m = (w == 4) ? 4'hf : ((w == 2) ? 4'h3 : 4'h1);
    for (int k = 0; k < sfxip_pkg::EDGE_DEPTH; k++) begin
      if (k < nClk) begin
        v = 24'((v << w) | 24'(ioMem_q[k] & m));
      end
    end
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // link domain: capture the first 40 rising serial clock edges of a frame
  // ----------------------------------------------------------------------
  // start flag is preset while deselected, so the frame that just
  // closed stays intact until the next frame's first edge
  always_ff @(posedge serialClk or posedge csN) begin
    if (csN) begin
      frameStart_q <= 1'b1;
    end else begin
      frameStart_q <= 1'b0;
    end
  end

  assign edgeIdx = frameStart_q ? '0 : edgeCnt_q;

  // edge counter saturates so long reads do not wrap
  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt_q <= '0;
    end else if (edgeIdx != '1) begin
      edgeCnt_q <= edgeIdx + 1'b1;
    end
  end

  // all four lines stored per edge, the decoder picks the lines later
  always_ff @(posedge serialClk) begin
    if (edgeIdx < sfxip_pkg::EDGE_CNT_W'(sfxip_pkg::EDGE_DEPTH)) begin
      ioMem_q[edgeIdx] <= {serialIoLine3, serialIoLine2,
                           serialIoLine1, serialIoLine0};
    end
  end

  // line 0 and line 3 high on every edge of the frame
  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      allOnes_q <= 1'b0;
    end else begin
      allOnes_q <= (frameStart_q | allOnes_q) & serialIoLine0 &
                   serialIoLine3;
    end
  end

  // one toggle per frame tells clk that fresh contents exist
  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      frameTog_q <= 1'b0;
    end else if (frameStart_q) begin
      frameTog_q <= ~frameTog_q;
    end
  end

  // ----------------------------------------------------------------------
  // crossing into the system clock domain
  // ----------------------------------------------------------------------
  sfxip_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h6) // idle levels: deselected, pin high, toggle low
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({csN, resetPinN, frameTog_q}),
    .syncOut (syncOut)
  );

  assign csSync     = syncOut[2];
  assign rstPinSync = syncOut[1];
  assign togSync    = syncOut[0];

  // frame closed: deselect seen and the toggle moved since last time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      csPrev_q  <= 1'b1;
      togSeen_q <= 1'b0;
    end else begin
      csPrev_q <= csSync;
      if (frameEnd) begin
        togSeen_q <= togSync;
      end
    end
  end

  assign frameEnd = csSync & ~csPrev_q & (togSync != togSeen_q);
  // pin reset ignored while selected, so a frame is never cut
  assign pinReset = resetPinEnable & ~rstPinSync & csSync;

  // ----------------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------------
  // xip frames carry address first; command frames carry a code first
  always_comb begin
    decWidth    = protoWidth(protocol_q);
    cmdClk      = sfxip_pkg::CMD_BITS / decWidth;
    addrClk     = sfxip_pkg::ADDR_BITS / decWidth;
    confIdx     = xipActive_q ? addrClk : cmdClk + addrClk;
    decCmd      = 8'(gatherBits(cmdClk, decWidth));
    decAddr     = '0;
    for (int k = 0; k < sfxip_pkg::EDGE_DEPTH; k++) begin
      if (k < addrClk) begin
        decAddr = 24'((decAddr << decWidth) |
                  24'(ioMem_q[xipActive_q ? k : k + cmdClk] &
                  ((decWidth == 4) ? 4'hf :
                   ((decWidth == 2) ? 4'h3 : 4'h1))));
      end
    end
    // line 0 only; lines 3..1 are don't care in this cycle
    decConfirm  = ioMem_q[confIdx][0];
    cmdSeen     = ~xipActive_q & (int'(edgeCnt_q) >= cmdClk);
    xipAllowed  = (vcrXipBit_q == sfxip_pkg::VCR_XIP_ON) | basicXip;
    // confirmation edge exists only if the host gave the dummy clock
    xipConfSeen = int'(edgeCnt_q) > confIdx;
    enterXip    = frameEnd & cmdSeen & ~powerUpBusy_q & xipAllowed &
                  (decCmd == sfxip_pkg::CMD_FAST_READ) & xipConfSeen &
                  (decConfirm == sfxip_pkg::CONFIRM_KEEP);
    // a line-0-high frame of 7, 13 or 25 clocks lands here
    exitXip     = frameEnd & xipActive_q & xipConfSeen &
                  (decConfirm == sfxip_pkg::CONFIRM_EXIT);
    rescueFf    = frameEnd & ~xipActive_q & allOnes_q &
                  (edgeCnt_q ==
                   sfxip_pkg::EDGE_CNT_W'(sfxip_pkg::RESCUE_FF_CLOCKS));
  end

  // ----------------------------------------------------------------------
  // boot capture and power-up phase
  // ----------------------------------------------------------------------
  // nonvolatile inputs are taken on the first edge after release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bootPending_q <= 1'b1;
    end else begin
      bootPending_q <= 1'b0;
    end
  end

  // power-up window during which only status reads and xip reads pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwrCnt_q      <= '0;
      powerUpBusy_q <= 1'b1;
    end else if (pwrCnt_q != PCNT_W'(PWRUP_CYCLES)) begin
      pwrCnt_q      <= pwrCnt_q + 1'b1;
      powerUpBusy_q <= (pwrCnt_q + 1'b1) != PCNT_W'(PWRUP_CYCLES);
    end else begin
      powerUpBusy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------------
  // xip flag and confirmation bit; pin reset and boot reload from nvcr
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xipActive_q     <= 1'b0;
      xipConfirmBit_q <= sfxip_pkg::CONFIRM_EXIT;
      viaVcr_q        <= 1'b0;
    end else if (bootPending_q | pinReset) begin
      // boot straight into xip with confirmation zero, unless the nvcr field reads disabled
      xipActive_q     <= nvcrXipField != sfxip_pkg::NVCR_XIP_DISABLED;
      xipConfirmBit_q <= (nvcrXipField != sfxip_pkg::NVCR_XIP_DISABLED) ?
                         sfxip_pkg::CONFIRM_KEEP :
                         sfxip_pkg::CONFIRM_EXIT;
      viaVcr_q        <= 1'b0;
    end else if (exitXip | rescueFf) begin
      // mode flag and confirmation bit move, plus the vcr bit after a vcr entry and the protocol on rescue; engines and status are untouched
      xipActive_q     <= 1'b0;
      xipConfirmBit_q <= sfxip_pkg::CONFIRM_EXIT;
      viaVcr_q        <= 1'b0;
    end else if (enterXip) begin
      xipActive_q     <= 1'b1;
      xipConfirmBit_q <= sfxip_pkg::CONFIRM_KEEP;
      viaVcr_q        <= ~basicXip;
    end
  end

  // volatile enable bit; set back to off (1) by hardware on exit after a vcr entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vcrXipBit_q <= sfxip_pkg::VCR_XIP_OFF;
    end else if (bootPending_q | pinReset) begin
      vcrXipBit_q <= sfxip_pkg::VCR_XIP_OFF;
    end else if (exitXip & viaVcr_q) begin
      vcrXipBit_q <= sfxip_pkg::VCR_XIP_OFF;
    end else if (vcrWrite & ~powerUpBusy_q) begin
      vcrXipBit_q <= vcrXipData;
    end
  end

  // protocol register; the all-ones byte forces extended mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      protocol_q <= sfxip_pkg::PROTO_EXT;
    end else if (bootPending_q | pinReset) begin
      protocol_q <= legalProto(nvcrProtocol);
    end else if (rescueFf) begin
      protocol_q <= sfxip_pkg::PROTO_EXT;
    end else if (protoWrite & ~powerUpBusy_q) begin
      protocol_q <= legalProto(protoData);
    end
  end

  // ----------------------------------------------------------------------
  // decoded frame outputs
  // ----------------------------------------------------------------------
  // one-cycle strobes; the code and address hold until the next frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdStrobe_q     <= 1'b0;
      cmdRejected_q   <= 1'b0;
      cmdCode_q       <= '0;
      xipReadStrobe_q <= 1'b0;
      readAddr_q      <= '0;
    end else begin
      cmdStrobe_q     <= frameEnd & cmdSeen;
      // early access limited to the two status reads
      cmdRejected_q   <= frameEnd & cmdSeen & powerUpBusy_q &
                         (decCmd != sfxip_pkg::CMD_READ_STATUS) &
                         (decCmd != sfxip_pkg::CMD_READ_FLAG);
      xipReadStrobe_q <= frameEnd & xipActive_q & xipConfSeen &
                         (decConfirm == sfxip_pkg::CONFIRM_KEEP);
      if (frameEnd & cmdSeen) begin
        cmdCode_q <= decCmd;
      end
      if (frameEnd & (xipActive_q | cmdSeen)) begin
        readAddr_q <= decAddr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // status bits cleared by power-on reset
  // ----------------------------------------------------------------------
  // write latch: set wins over clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeEnableLatch_q <= 1'b0;
    end else if (welSet & ~powerUpBusy_q) begin
      writeEnableLatch_q <= 1'b1;
    end else if (welClear) begin
      writeEnableLatch_q <= 1'b0;
    end
  end

  // write in progress mirrors the engines, xip exit never stops them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeInProgress_q <= 1'b0;
    end else begin
      writeInProgress_q <= engineBusy;
    end
  end

  // lock bits {write lock, lock down} start at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockBits_q <= '0;
    end else if (lockWrite & ~powerUpBusy_q) begin
      lockBits_q <= lockData;
    end
  end

endmodule // sfxip_ctrl

// ===== logic/sfxip_sync.sv
// Purpose: shared constants for the execute-in-place control block and
//          the two-flop synchroniser that it uses for select, reset pin and frame toggle.
// Assumes: destination clock runs while the crossed value matters.
// Notes:   the first flop of each stage feeds only the second one.

`timescale 1ns/1ps

// ----------------------------------------------------------------------
// shared constants
// ----------------------------------------------------------------------
package sfxip_pkg;

  // serial protocol currently enabled on the data lines
  typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} sfxip_proto_e;

  // system clock and power-up timing
  localparam int CLK_FREQ_MHZ             = 50;
  localparam int SUPPLY_TO_READ_US        = 150;
  localparam int SUPPLY_TO_FULL_ACCESS_US = 150;
  localparam int PWRUP_CYCLES = SUPPLY_TO_FULL_ACCESS_US * CLK_FREQ_MHZ;

  // nonvolatile execute-in-place field, erased value means disabled
  localparam int         NVCR_XIP_MSB      = 11;
  localparam int         NVCR_XIP_LSB      = 9;
  localparam logic [2:0] NVCR_XIP_DISABLED = 3'h7;

  // volatile configuration bit 3: 0 enables, 1 disables
  localparam int   VCR_XIP_BIT  = 3;
  localparam logic VCR_XIP_ON   = 1'b0;
  localparam logic VCR_XIP_OFF  = 1'b1;

  // confirmation bit meaning
  localparam logic CONFIRM_KEEP = 1'b0;
  localparam logic CONFIRM_EXIT = 1'b1;

  // frame layout
  localparam int CMD_BITS         = 8;
  localparam int ADDR_BITS        = 24;
  localparam int RESCUE_FF_CLOCKS = 8;
  localparam int EDGE_DEPTH       = 40;
  localparam int EDGE_CNT_W       = 6;
  localparam int IO_W             = 4;

  // command codes seen by this block
  localparam logic [7:0] CMD_FAST_READ   = 8'h0b;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_FLAG   = 8'h70;

endpackage

// ----------------------------------------------------------------------
// two-flop synchroniser
// ----------------------------------------------------------------------
module sfxip_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset of the destination domain
  input  wire logic             clk,
  input  wire logic             rst_n,
  // crossing value
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // metastability guard, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule // sfxip_sync
